//--- fcp_host.sv
// fcp_host: AHB-Lite driven controller for a byte-wide flash command port
module fcp_host
  import fcp_pkg::*;
#(
  parameter int unsigned WP_CYC = FCP_WP_CYC,
  parameter int unsigned ACC_CYC = FCP_ACC_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // flash pins
  output fcp_pins_t flash_o,
  input wire logic [7:0] flash_dq_i
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // counter is 8 bits and is loaded with length plus one
  if (WP_CYC < 1 || WP_CYC > 254) begin : g_bad_wp
    $error("fcp_host: WP_CYC out of range");
  end
  if (ACC_CYC < 1 || ACC_CYC > 254) begin : g_bad_acc
    $error("fcp_host: ACC_CYC out of range");
  end
  localparam logic [7:0] WP_LOAD = 8'(WP_CYC + 1);
  localparam logic [7:0] ACC_LOAD = 8'(ACC_CYC + 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // only the defined command set may go out
  function automatic logic cmd_ok(input logic [7:0] b);
    cmd_ok = (b == FCP_CMD_ARRAY) || (b == FCP_CMD_IDENT) ||
             (b == FCP_CMD_STATUS) || (b == FCP_CMD_CLEAR) ||
             (b == FCP_CMD_SUSPEND) || (b == FCP_CMD_CONFIRM);
  endfunction

  // decide whether an order may start
  function automatic logic start_ok(input logic [2:0] op, input logic [7:0] b,
                                    input logic vlow, input logic dbusy);
    case (op)
      FCP_OP_CMD: start_ok = cmd_ok(b) && !(dbusy && b == FCP_CMD_ARRAY);
      FCP_OP_READ, FCP_OP_POLL: start_ok = 1'b1;
      FCP_OP_ERASE, FCP_OP_PROG: start_ok = !vlow;
      default: start_ok = 1'b0;
    endcase
  endfunction

  // bus cycle for each step of an order
  function automatic fcp_cycle_t cycle_of(input fcp_op_t op, input logic step,
                                          input logic [7:0] wd);
    cycle_of = '{wr: 1'b1, data: wd};
    case (op)
      FCP_OP_READ: cycle_of.wr = 1'b0;
      FCP_OP_ERASE: cycle_of.data = step ? FCP_CMD_CONFIRM : FCP_CMD_ERASE;
      FCP_OP_PROG: cycle_of.data = step ? wd : FCP_CMD_PROG;
      FCP_OP_POLL: begin
        cycle_of.wr = !step;
        cycle_of.data = FCP_CMD_STATUS;
      end
      default: cycle_of.data = wd;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  fcp_regs_t r_ff;
  fcp_regs_t nxt_r;
  fcp_cycle_t cyc;
  logic last_step;
  logic [7:0] poll_mask;
  logic [7:0] rd_byte;

  assign cyc = cycle_of(r_ff.op, r_ff.step, r_ff.wdata);
  assign last_step = (r_ff.op == FCP_OP_CMD) || (r_ff.op == FCP_OP_READ) || r_ff.step;
  assign poll_mask = r_ff.suspw ? FCP_POLL_SUSP : FCP_POLL_DONE;
  // reserved status bits are masked off
  assign rd_byte = (r_ff.mode == FCP_MODE_STATUS) ? (flash_dq_i & FCP_SR_USED) : flash_dq_i;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_r = r_ff;
    // address phase capture, one word per register
    if (hready) begin
      nxt_r.bus_act = hsel && htrans[1];
      nxt_r.bus_wr = hwrite;
      nxt_r.bus_idx = haddr[4:2];
    end

    // data phase writes
    if (r_ff.bus_act && r_ff.bus_wr) begin
      case (r_ff.bus_idx)
        FCP_IDX_CTRL: begin
          if (r_ff.busy || !r_ff.pins.powerdown_reset_n ||
              !start_ok(hwdata[2:0], r_ff.wdata, r_ff.vlow, r_ff.dbusy)) begin
            nxt_r.refused = 1'b1;
          end else begin
            nxt_r.refused = 1'b0;
            nxt_r.busy = 1'b1;
            nxt_r.op = fcp_op_t'(hwdata[2:0]);
            nxt_r.suspw = hwdata[FCP_CTRL_SUSPW];
            nxt_r.step = 1'b0;
            nxt_r.st = FCP_ST_SETUP;
          end
        end
        FCP_IDX_ADDR: nxt_r.addr = hwdata[FCP_ADDR_W-1:0];
        FCP_IDX_WDATA: nxt_r.wdata = hwdata[7:0];
        FCP_IDX_PIN: begin
          // never cut a bus cycle short with power-down
          if (r_ff.busy) begin
            nxt_r.refused = 1'b1;
          end else begin
            nxt_r.pins.powerdown_reset_n = hwdata[0];
            if (!r_ff.pins.powerdown_reset_n && hwdata[0]) begin
              nxt_r.mode = FCP_MODE_ARRAY;
              nxt_r.lstat = FCP_SR_WAKE;
              nxt_r.dbusy = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    // flash bus cycle sequencer
    case (r_ff.st)
      FCP_ST_IDLE: ;
      FCP_ST_SETUP: begin
        // address, select and data settle before the strobe
        nxt_r.pins.addr = r_ff.addr;
        nxt_r.pins.ce_n = 1'b0;
        nxt_r.pins.dq_oe = cyc.wr;
        nxt_r.pins.dq_o = cyc.data;
        nxt_r.cnt = cyc.wr ? WP_LOAD : ACC_LOAD;
        nxt_r.st = FCP_ST_PULSE;
      end
      FCP_ST_PULSE: begin
        nxt_r.cnt = r_ff.cnt - 8'h01;
        if (r_ff.cnt == 8'h01) begin
          // rising write strobe latches address and data
          nxt_r.pins.we_n = 1'b1;
          nxt_r.pins.oe_n = 1'b1;
          nxt_r.st = FCP_ST_HOLD;
          if (!cyc.wr) begin
            nxt_r.rdata = rd_byte;
            if (r_ff.mode == FCP_MODE_STATUS) begin
              nxt_r.lstat = rd_byte;
              // a low-supply abort stays flagged until cleared
              if (rd_byte[FCP_SB_SUPPLY_LOW]) begin
                nxt_r.vlow = 1'b1;
              end
              if (rd_byte[FCP_SB_READY]) begin
                nxt_r.dbusy = 1'b0;
              end
            end
          end
        end else begin
          nxt_r.pins.we_n = !cyc.wr;
          nxt_r.pins.oe_n = cyc.wr;
        end
      end
      FCP_ST_HOLD: begin
        // data held past the strobe, then select released
        nxt_r.pins.ce_n = 1'b1;
        nxt_r.pins.dq_oe = 1'b0;
        nxt_r.st = FCP_ST_GAP;
      end
      FCP_ST_GAP: begin
        if (cyc.wr) begin
          // track which read mode the device is in
          case (cyc.data)
            FCP_CMD_ARRAY: nxt_r.mode = FCP_MODE_ARRAY;
            FCP_CMD_IDENT: nxt_r.mode = FCP_MODE_IDENT;
            FCP_CMD_CLEAR: nxt_r.vlow = 1'b0;
            FCP_CMD_CONFIRM, FCP_CMD_STATUS, FCP_CMD_SUSPEND: nxt_r.mode = FCP_MODE_STATUS;
            default: ;
          endcase
          if ((r_ff.op == FCP_OP_ERASE || r_ff.op == FCP_OP_PROG) && r_ff.step) begin
            // sequencer now runs; supply is judged from here on
            nxt_r.mode = FCP_MODE_STATUS;
            nxt_r.dbusy = 1'b1;
          end
        end
        if (r_ff.op == FCP_OP_POLL && r_ff.step &&
            ((r_ff.rdata & poll_mask) != poll_mask)) begin
          // another status read; the gap refreshes the latch
          nxt_r.st = FCP_ST_SETUP;
        end else if (!last_step) begin
          nxt_r.step = 1'b1;
          nxt_r.st = FCP_ST_SETUP;
        end else begin
          nxt_r.busy = 1'b0;
          nxt_r.st = FCP_ST_IDLE;
        end
      end
      default: nxt_r.st = FCP_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '{st: FCP_ST_IDLE, op: FCP_OP_CMD, mode: FCP_MODE_ARRAY,
                lstat: FCP_SR_WAKE,
                pins: '{addr: '0, dq_o: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                        oe_n: 1'b1, we_n: 1'b1, powerdown_reset_n: 1'b1},
                default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  // zero wait states, so hreadyout never stalls
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign flash_o = r_ff.pins;

  // read mux; unmapped words read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (r_ff.bus_act && !r_ff.bus_wr) begin
      case (r_ff.bus_idx)
        FCP_IDX_CTRL: hrdata = {28'h0000000, r_ff.suspw, r_ff.op};
        FCP_IDX_ADDR: hrdata = {15'h0000, r_ff.addr};
        FCP_IDX_WDATA: hrdata = {24'h000000, r_ff.wdata};
        FCP_IDX_RDATA: hrdata = {24'h000000, r_ff.rdata};
        FCP_IDX_STAT: hrdata = {16'h0000, r_ff.lstat, 2'b00, r_ff.mode,
                                r_ff.dbusy, r_ff.vlow, r_ff.refused, r_ff.busy};
        FCP_IDX_PIN: hrdata = {31'h00000000, r_ff.pins.powerdown_reset_n};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- fcp_pkg.sv
// fcp_pkg: constants and types for the flash command port controller
package fcp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned FCP_CLK_MHZ = 100;
  localparam int unsigned FCP_T_WP_NS = 50;
  localparam int unsigned FCP_T_ACC_NS = 120;
  // least times round up to whole cycles
  localparam int unsigned FCP_WP_CYC = (FCP_T_WP_NS * FCP_CLK_MHZ + 999) / 1000;
  localparam int unsigned FCP_ACC_CYC = (FCP_T_ACC_NS * FCP_CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // device command bytes
  // ----------------------------------------
  localparam logic [7:0] FCP_CMD_ARRAY = 8'hff;
  localparam logic [7:0] FCP_CMD_IDENT = 8'h90;
  localparam logic [7:0] FCP_CMD_STATUS = 8'h70;
  localparam logic [7:0] FCP_CMD_CLEAR = 8'h50;
  localparam logic [7:0] FCP_CMD_ERASE = 8'h20;
  localparam logic [7:0] FCP_CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] FCP_CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] FCP_CMD_PROG = 8'h40;

  // ----------------------------------------
  // device status byte
  // ----------------------------------------
  localparam int FCP_SB_READY = 7;
  localparam int FCP_SB_SUPPLY_LOW = 3;
  localparam logic [7:0] FCP_SR_USED = 8'hf8;
  localparam logic [7:0] FCP_SR_WAKE = 8'h80;
  localparam logic [7:0] FCP_POLL_DONE = 8'h80;
  localparam logic [7:0] FCP_POLL_SUSP = 8'hc0;

  // ----------------------------------------
  // controller registers (word index = haddr[4:2])
  // ----------------------------------------
  localparam logic [2:0] FCP_IDX_CTRL = 3'h0;
  localparam logic [2:0] FCP_IDX_ADDR = 3'h1;
  localparam logic [2:0] FCP_IDX_WDATA = 3'h2;
  localparam logic [2:0] FCP_IDX_RDATA = 3'h3;
  localparam logic [2:0] FCP_IDX_STAT = 3'h4;
  localparam logic [2:0] FCP_IDX_PIN = 3'h5;
  localparam int FCP_CTRL_SUSPW = 3;
  localparam int FCP_ADDR_W = 17;

  typedef enum logic [2:0] {
    FCP_OP_CMD = 3'h0,
    FCP_OP_READ = 3'h1,
    FCP_OP_ERASE = 3'h2,
    FCP_OP_PROG = 3'h3,
    FCP_OP_POLL = 3'h4
  } fcp_op_t;

  typedef enum logic [1:0] {
    FCP_MODE_ARRAY = 2'h0,
    FCP_MODE_IDENT = 2'h1,
    FCP_MODE_STATUS = 2'h2
  } fcp_mode_t;

  // gray codes along idle-setup-pulse-hold-gap
  typedef enum logic [2:0] {
    FCP_ST_IDLE = 3'b000,
    FCP_ST_SETUP = 3'b001,
    FCP_ST_PULSE = 3'b011,
    FCP_ST_HOLD = 3'b010,
    FCP_ST_GAP = 3'b110
  } fcp_state_t;

  typedef struct packed {
    logic [FCP_ADDR_W-1:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic powerdown_reset_n;
  } fcp_pins_t;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } fcp_cycle_t;

  typedef struct packed {
    fcp_state_t st;
    logic [7:0] cnt;
    fcp_op_t op;
    logic suspw;
    logic step;
    logic [FCP_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] lstat;
    logic busy;
    logic refused;
    logic vlow;
    logic dbusy;
    fcp_mode_t mode;
    logic bus_act;
    logic bus_wr;
    logic [2:0] bus_idx;
    fcp_pins_t pins;
  } fcp_regs_t;

endpackage

//--- fcp_host_asserts.sv
// fcp_host_asserts: pin timing checks for the flash controller
module fcp_host_asserts
  import fcp_pkg::*;
#(
  parameter int unsigned WP_CYC = 5,
  parameter int unsigned ACC_CYC = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // flash pins
  input fcp_pins_t flash_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] we_cnt_ff;
  logic [7:0] oe_cnt_ff;
  // -----
  // strobe widths, counted in sampled low cycles
  // -----
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_cnt_ff <= 8'h00;
      oe_cnt_ff <= 8'h00;
    end else begin
      we_cnt_ff <= flash_o.we_n ? 8'h00 : we_cnt_ff + 8'h01;
      oe_cnt_ff <= flash_o.oe_n ? 8'h00 : oe_cnt_ff + 8'h01;
    end
  end
  a_we_in_ce: assert property (!flash_o.we_n |-> !flash_o.ce_n)
    else $error("write strobe outside select");
  a_we_width: assert property ($rose(flash_o.we_n) |-> we_cnt_ff == 8'(WP_CYC))
    else $error("write strobe width wrong");
  a_oe_width: assert property ($rose(flash_o.oe_n) |-> oe_cnt_ff == 8'(ACC_CYC))
    else $error("read strobe width wrong");
  a_no_clash: assert property (!flash_o.oe_n |-> !flash_o.dq_oe && flash_o.we_n)
    else $error("data bus contention");
  a_data_setup: assert property ($fell(flash_o.we_n) |-> $past(!flash_o.ce_n) && flash_o.dq_oe)
    else $error("data not set up before strobe");
  a_addr_held: assert property (!flash_o.ce_n && $past(!flash_o.ce_n) |->
    $stable(flash_o.addr) && $stable(flash_o.dq_o))
    else $error("address or data moved in a cycle");
  a_ce_gap: assert property ($rose(flash_o.oe_n) |-> !flash_o.ce_n ##1 flash_o.ce_n)
    else $error("select not raised after read");
  a_pd_quiet: assert property (!flash_o.powerdown_reset_n |-> flash_o.ce_n && flash_o.we_n)
    else $error("access during power-down");
endmodule

bind fcp_host fcp_host_asserts #(.WP_CYC(WP_CYC), .ACC_CYC(ACC_CYC)) chk_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .flash_o(flash_o)
);

//--- fcp_flash_model.sv
// fcp_flash_model: behavioural byte-wide flash with command port
module fcp_flash_model
  import fcp_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'ha7, // arbitrary value
  parameter int BUSY_READS = 2
) (
  // pins from the controller
  input fcp_pins_t pins,
  input wire logic supply_high,
  // data back
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sr, latch, last;
  logic [1:0] mode;
  logic [1:0] pend;
  int busy_left;
  // -----
  // wake: array mode, status 80h
  // -----
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge pins.powerdown_reset_n) begin
    mode = 2'd0;
    sr = FCP_SR_WAKE;
    pend = 2'd0;
    busy_left = 0;
    last = 8'h00;
  end
  // command latch takes address and data on the rising strobe
  always @(posedge pins.we_n) if (!pins.ce_n && pins.powerdown_reset_n) begin
    if (pend != 2'd0) begin
      if (pend == 2'd1 && pins.dq_o != FCP_CMD_CONFIRM) sr[5:4] = 2'b11;
      else if (!supply_high) sr[3] = 1'b1;
      else begin
        if (pend == 2'd2) mem[pins.addr[7:0]] = pins.dq_o;
        sr[7] = 1'b0;
        busy_left = BUSY_READS;
      end
      pend = 2'd0;
      mode = 2'd2;
    end else case (pins.dq_o)
      FCP_CMD_ARRAY: if (sr[7]) mode = 2'd0;
      FCP_CMD_IDENT: mode = 2'd1;
      FCP_CMD_STATUS: mode = 2'd2;
      FCP_CMD_CLEAR: sr[5:3] = 3'b000;
      FCP_CMD_ERASE: pend = 2'd1;
      FCP_CMD_PROG: pend = 2'd2;
      FCP_CMD_SUSPEND: if (!sr[7]) sr[7:6] = 2'b11;
      default: ;
    endcase
  end
  // status latched on the later falling edge; busy ends after a few reads
  always @(negedge pins.oe_n or negedge pins.ce_n) if (!pins.oe_n && !pins.ce_n) begin
    latch = sr & FCP_SR_USED;
    if (busy_left > 0) busy_left--;
    if (busy_left == 0 && sr[6] == 1'b0) sr[7] = 1'b1;
  end
  always @(posedge pins.oe_n) last = dq;
  // a released bus shows the inverse of the last byte, never a held value
  always @* begin
    if (pins.ce_n || pins.oe_n || !pins.powerdown_reset_n) dq = ~last;
    else if (mode == 2'd0) dq = mem[pins.addr[7:0]];
    else if (mode == 2'd1) dq = pins.addr[0] ? PART_CODE : MAKER_CODE;
    else dq = latch;
  end
endmodule

//--- tb.sv
// tb: bus-level tests of the flash controller against the device model
module tb;
  import fcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] PART = 8'ha7; // arbitrary value
  logic core_clk = 1'b0;
  // starts high so that the first assertion is a real falling edge for the async reset
  logic rst_n = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic supply_high = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic [7:0] dq;
  fcp_pins_t pins;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  fcp_host #(.WP_CYC(2), .ACC_CYC(3)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_o(pins), .flash_dq_i(dq));
  fcp_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (.pins(pins),
    .supply_high(supply_high), .dq(dq));
  // -----
  // clock, timeout and closing report
  // -----
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one ahb single transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [2:0] idx, input logic [31:0] wd, output logic [31:0] rv);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {27'h0, idx, 2'h0};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rv = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [2:0] idx, input logic [31:0] msk, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0, rd);
    chk(rd & msk, exp);
  endtask
  // start one controller operation and wait until it is idle again
  task automatic run(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d);
    ahb(1'b1, FCP_IDX_ADDR, {15'h0, a}, rd);
    ahb(1'b1, FCP_IDX_WDATA, {24'h0, d}, rd);
    ahb(1'b1, FCP_IDX_CTRL, {28'h0, op}, rd);
    do ahb(1'b0, FCP_IDX_STAT, 32'h0, rd); while (rd[0] !== 1'b0);
  endtask
  // -----
  // test sequence
  // -----
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rc(FCP_IDX_STAT, 32'hff3f, 32'h8000);
    rc(3'h6, 32'hffffffff, 32'h0);
    for (int i = 0; i < 2; i++) begin
      run(FCP_OP_READ, 17'h12 + 17'(i), 8'h0);
      rc(FCP_IDX_RDATA, 32'hff, {24'h0, 8'h12 + 8'(i)} ^ 32'h5a);
    end
    run(FCP_OP_CMD, 17'h0, FCP_CMD_IDENT);
    for (int i = 0; i < 2; i++) begin
      run(FCP_OP_READ, 17'(i), 8'h0);
      rc(FCP_IDX_RDATA, 32'hff, {24'h0, (i == 1) ? PART : MAKER});
    end
    rc(FCP_IDX_STAT, 32'h30, 32'h10);
    run(FCP_OP_CMD, 17'h0, FCP_CMD_STATUS);
    run(FCP_OP_READ, 17'h5, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'h80);
    // array command is held back while the device is busy
    run(FCP_OP_PROG, 17'h33, 8'ha5);
    run(FCP_OP_CMD, 17'h0, FCP_CMD_ARRAY);
    rc(FCP_IDX_STAT, 32'h2, 32'h2);
    run(FCP_OP_POLL, 17'h0, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'h80);
    run(FCP_OP_CMD, 17'h0, FCP_CMD_ARRAY);
    run(FCP_OP_READ, 17'h33, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'ha5);
    // low supply: erase aborts, further writes held until cleared
    supply_high <= 1'b0;
    run(FCP_OP_ERASE, 17'h40, 8'h0);
    run(FCP_OP_POLL, 17'h0, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'h88);
    run(FCP_OP_PROG, 17'h41, 8'h0);
    rc(FCP_IDX_STAT, 32'h6, 32'h6);
    run(FCP_OP_CMD, 17'h0, FCP_CMD_CLEAR);
    run(FCP_OP_POLL, 17'h0, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'h80);
    rc(FCP_IDX_STAT, 32'h6, 32'h0);
    supply_high <= 1'b1;
    run(FCP_OP_CMD, 17'h0, 8'h11);
    rc(FCP_IDX_STAT, 32'h2, 32'h2);
    run(FCP_OP_ERASE, 17'h50, 8'h0);
    run(FCP_OP_CMD, 17'h0, FCP_CMD_SUSPEND);
    run(4'hc, 17'h0, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'hc0);
    ahb(1'b1, FCP_IDX_PIN, 32'h0, rd);
    ahb(1'b1, FCP_IDX_PIN, 32'h1, rd);
    rc(FCP_IDX_STAT, 32'hff30, 32'h8000);
    run(FCP_OP_POLL, 17'h0, 8'h0);
    rc(FCP_IDX_RDATA, 32'hff, 32'h80);
    summarize();
  end
endmodule
